/* bench/act_core_model.sv */
// conversion core stand-in: answers each start request with one result strobe
// assumes the start bit stays high until the block takes the result
`timescale 1ns/1ps
module act_core_model
   import act_pkg::*;
(
   input wire logic aclk, // block clock
   input wire logic aresetn, // sync reset, low active
   input wire logic conversion_start_bit, // start request
   input wire logic [9:0] sample, // value to convert
   output act_pkg::act_conv_t conv_in // result strobe
);
   logic [2:0] cnt_q;
   logic [9:0] last_q;
   // convert only on request
   // skip the strobe cycle so a cleared start bit is seen first
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 3'h0;
         last_q <= 10'h000;
         conv_in <= '0;
      end else begin
         if (cnt_q == 3'h3) begin
            cnt_q <= 3'h0;
            conv_in <= {1'b1, sample};
            last_q <= sample;
         end else begin
            conv_in <= {1'b0, ~last_q}; // no stale value outside strobe
            if (cnt_q != 3'h0 || (conversion_start_bit && !conv_in.valid)) cnt_q <= cnt_q + 3'h1;
         end
      end
   end
endmodule

/* bench/adc_computation_threshold_bench.sv */
// bench for act_top: register tasks over AXI4-Lite, core model on the result side
// assumes a 10 MHz clock and the register map of act_pkg
`timescale 1ns/1ps
module adc_computation_threshold_bench;
   import act_pkg::*;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
   logic [31:0] awa = 0, wd = 0, ara = 0, rd;
   logic awr, wr, bv, arr, rv, go, tif;
   logic [1:0] br, rr, resp;
   logic [9:0] sample = 0;
   act_conv_t conv;
   int errors = 0, tests_run = 0, cyc = 0;
   act_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .conv_in(conv),
      .conversion_start_bit(go), .threshold_irq_flag(tif));
   act_core_model core (.aclk(aclk), .aresetn(aresetn), .conversion_start_bit(go), .sample(sample),
      .conv_in(conv));
   // clock and hang guard
   initial forever #50 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %b seen %b", n, e, g);
      end
   endtask
   // write: address and data offered together, each released when taken
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awa <= {24'h0, a};
      wd <= d;
      awv <= 1;
      wv <= 1;
      bre <= 1;
      do begin
         @(posedge aclk);
         if (awv && awr) awv <= 0;
         if (wv && wr) wv <= 0;
         if (bre && bv) bre <= 0;
      end while (awv || wv || !bv);
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      ara <= {24'h0, a};
      arv <= 1;
      rre <= 1;
      do begin
         @(posedge aclk);
         if (arv && arr) arv <= 0;
      end while (!rv);
      rre <= 0;
      d = rd;
      resp = rr;
   endtask
   task automatic chk_reg(input string n, input logic [7:0] a, input logic [15:0] e);
      logic [31:0] v;
      rd_reg(a, v);
      chk(n, e, v[15:0]);
   endtask
   // start one conversion cycle and wait until the start bit falls
   task automatic run(input logic [31:0] ctrl, input logic [9:0] s);
      sample <= s;
      wr_reg(ACT_OFF_CTRL, ctrl);
      @(posedge aclk);
      while (go) @(posedge aclk);
      repeat (2) @(posedge aclk);
   endtask
   logic [31:0] v;
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      // basic, raw result, above upper
      wr_reg(ACT_OFF_UTH, 32'h0000_0064);
      run(32'h0003_01B0, 10'h0C8);
      chk_reg("res_right", ACT_OFF_RES, 16'h00C8);
      chk_reg("err_raw", ACT_OFF_ERR, 16'h00C8);
      chk_reg("acc_basic", ACT_OFF_ACC, 16'h0000);
      chk_bit("tif_upper", 1'b1, tif);
      wr_reg(ACT_OFF_STAT, 32'h0000_0001);
      chk_bit("tif_clr", 1'b0, tif);
      rd_reg(8'h40, v);
      chk("unmapped", {14'h0, ACT_RESP_SLVERR}, {14'h0, resp});
      $display("test basic done");
      // accumulate, left format, shift one, never interrupt
      wr_reg(ACT_OFF_CTRL, 32'h0004_0201);
      run(32'h0002_0201, 10'h12C);
      run(32'h0002_0201, 10'h12C);
      chk_reg("acc_sum", ACT_OFF_ACC, 16'h0258);
      chk_reg("res_left", ACT_OFF_RES, 16'h4B00);
      chk_reg("flt_shift", ACT_OFF_FLT, 16'h012C);
      chk_reg("cnt_acc", ACT_OFF_CNT, 16'h0002);
      chk_bit("tif_never", 1'b0, tif);
      $display("test accumulate done");
      // burst average of four from one start
      wr_reg(ACT_OFF_RPT, 32'h0000_0004);
      wr_reg(ACT_OFF_CTRL, 32'h0004_0003);
      run(32'h0002_0003, 10'h064);
      chk_reg("cnt_burst", ACT_OFF_CNT, 16'h0004);
      chk_reg("acc_burst", ACT_OFF_ACC, 16'h0190);
      chk_bit("go_burst", 1'b0, go);
      $display("test burst done");
      // result minus setpoint, negative, below lower
      wr_reg(ACT_OFF_STPT, 32'h0000_01F4);
      wr_reg(ACT_OFF_LTH, 32'h0000_0000);
      run(32'h0003_0048, 10'h064);
      chk_reg("err_stpt", ACT_OFF_ERR, 16'hFE70);
      chk_bit("tif_signed", 1'b1, tif);
      $display("test setpoint done");
      // double sampling: first half only records, second computes
      wr_reg(ACT_OFF_STAT, 32'h0000_0011);
      run(32'h0003_4038, 10'h050);
      chk_reg("err_first", ACT_OFF_ERR, 16'hFE70);
      chk_reg("stat_first", ACT_OFF_STAT, 16'h0018);
      run(32'h0003_4038, 10'h0C8);
      chk_reg("prev_dbl", ACT_OFF_PREV, 16'h0050);
      chk_reg("res_dbl", ACT_OFF_RES, 16'h00C8);
      chk_reg("err_dbl", ACT_OFF_ERR, 16'h0078);
      chk_bit("tif_dbl", 1'b1, tif);
      $display("test double done");
      // average of two, continuous retrigger, stop on interrupt
      wr_reg(ACT_OFF_CTRL, 32'h0004_31BA);
      wr_reg(ACT_OFF_STAT, 32'h0000_0001);
      wr_reg(ACT_OFF_RPT, 32'h0000_0002);
      run(32'h0003_31BA, 10'h020);
      chk_reg("acc_avg", ACT_OFF_ACC, 16'h0040);
      chk_reg("cnt_avg", ACT_OFF_CNT, 16'h0002);
      chk_reg("err_avg", ACT_OFF_ERR, 16'h0020);
      chk_bit("go_soi", 1'b0, go);
      chk_bit("tif_avg", 1'b1, tif);
      $display("test average done");
      end_sim();
   end
endmodule

/* design/act_pkg.sv */
// package for the conversion post-processing block: register map, field layout, reset values
// assumes a 32-bit AXI4-Lite register bus and one clock
package act_pkg;
   localparam int ACT_RES_W = 10;
   localparam int ACT_DATA_W = 16;
   // register byte offsets
   localparam logic [7:0] ACT_OFF_CTRL = 8'h00;
   localparam logic [7:0] ACT_OFF_STAT = 8'h04;
   localparam logic [7:0] ACT_OFF_RPT = 8'h08;
   localparam logic [7:0] ACT_OFF_STPT = 8'h0C;
   localparam logic [7:0] ACT_OFF_LTH = 8'h10;
   localparam logic [7:0] ACT_OFF_UTH = 8'h14;
   localparam logic [7:0] ACT_OFF_RES = 8'h18;
   localparam logic [7:0] ACT_OFF_PREV = 8'h1C;
   localparam logic [7:0] ACT_OFF_ACC = 8'h20;
   localparam logic [7:0] ACT_OFF_FLT = 8'h24;
   localparam logic [7:0] ACT_OFF_ERR = 8'h28;
   localparam logic [7:0] ACT_OFF_CNT = 8'h2C;
   // control register field positions
   localparam int ACT_B_MODE = 0;  // 3 bits
   localparam int ACT_B_TMD = 3;   // 3 bits
   localparam int ACT_B_CALC = 6;  // 3 bits
   localparam int ACT_B_CRS = 9;   // 3 bits
   localparam int ACT_B_CONT = 12;
   localparam int ACT_B_SOI = 13;
   localparam int ACT_B_DSEN = 14;
   localparam int ACT_B_PSIS = 15;
   localparam int ACT_B_FM = 16;
   localparam int ACT_B_GO = 17;
   localparam int ACT_B_ACLR = 18;
   // status register field positions
   localparam int ACT_B_TIF = 0;
   localparam int ACT_B_AOV = 1;
   localparam int ACT_B_UTHR = 2;
   localparam int ACT_B_LTHR = 3;
   localparam int ACT_B_MATH = 4;
   localparam logic [15:0] ACT_CTRL_RST = 16'h0000;
   localparam logic [7:0] ACT_RPT_RST = 8'h00;
   localparam logic [7:0] ACT_CNT_MAX = 8'hFF;
   localparam logic [1:0] ACT_RESP_OKAY = 2'b00;
   localparam logic [1:0] ACT_RESP_SLVERR = 2'b10;

   typedef enum logic [2:0] {
      ACT_MD_BASIC, ACT_MD_ACCUM, ACT_MD_AVG, ACT_MD_BURST, ACT_MD_LPF
   } act_mode_t;

   // settings that steer the computation
   typedef struct packed {
      logic pre_src_sel;
      logic dbl_en;
      logic stop_irq;
      logic cont_en;
      logic [2:0] shift;
      logic [2:0] calc;
      logic [2:0] tmode;
      logic [2:0] mode;
   } act_ctrl_t;

   // one conversion result from the core
   typedef struct packed {
      logic valid;
      logic [ACT_RES_W-1:0] data;
   } act_conv_t;
endpackage

/* design/act_top.sv */
// conversion post-processing: accumulate/average/filter, error calculation, threshold test
// assumes conversion results arrive as one-cycle strobes in step with aclk; AXI4-Lite slave
//
// Operation
// (RQ1) basic mode skips accumulation yet still computes error and tests threshold
// (RQ2) accumulate mode adds each completed result into the accumulator
// (RQ3) filter output takes the accumulator shifted right by shift count
// (RQ4) accumulator is always right-justified regardless of result format
// (RQ5) sample counter counts once per accumulated sample
// (RQ6) accumulate mode tests threshold after every sample
// (RQ7) average mode tests threshold only when counter reaches repeat target
// (RQ8) burst average retriggers itself until counter reaches repeat target
// (RQ9) low-pass mode filters samples, shift sets the cutoff
// (RQ10) error codes 0-2: result minus previous, setpoint or filter
// (RQ11) codes 4-7: previous-filter, filter-setpoint, result, filter; 3 reserved
// (RQ12) upper and lower compare flags come from comparing error with thresholds
// (RQ13) threshold mode selects one of eight conditions
// (RQ14) met condition at end of computation sets threshold flag
// (RQ15) threshold comparisons are signed
// (RQ16) accumulator overflow also raises threshold flag
// (RQ17) results are latched at end of conversion and held
// (RQ18) continuous mode sets start bit again until stop-on-interrupt
// (RQ19) double sampling needs two conversions, each triggered when not continuous
// (RQ20) first double-sample conversion sets done flag and updates accumulator only
// (RQ21) second conversion moves first to previous, second to result, then tests
// (RQ22) accumulator is 16 bits; overflow flag set when sum passes 65535; the code does not set it in low-pass mode
// (RQ23) clear bit clears accumulator, overflow and counter, then self-clears
`timescale 1ns/1ps
module act_top
   import act_pkg::*;
#(
   parameter int RES_W = act_pkg::ACT_RES_W
) (
   input wire logic aclk, // 10 MHz clock
   input wire logic aresetn, // synchronous reset, low active
   input wire logic [31:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [31:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire act_pkg::act_conv_t conv_in, // finished conversion strobe
   output logic conversion_start_bit, // asks core for a conversion
   output logic threshold_irq_flag // sticky threshold flag
);
   import act_pkg::*;

   // elaboration check: results wider than the 16-bit registers cannot be shown
   if (RES_W < 1 || RES_W > 16) begin : g_res_w_check
      $error("act_top: RES_W out of range");
   end

   act_ctrl_t ctrl_q;
   logic result_left_q;
   logic [7:0] repeat_target_q;
   logic [15:0] setpoint_value_q, lower_threshold_q, upper_threshold_q;
   logic [15:0] conversion_result_q, previous_result_q;
   logic [15:0] sample_accumulator_q, filter_output_q, error_value_q;
   logic [7:0] sample_counter_q;
   logic accumulator_overflow_flag_q, upper_compare_flag_q, lower_compare_flag_q;
   logic computation_done_flag_q, accumulator_clear_q, second_pending_q;
   logic tif_q, start_fresh_q;

   // bus channel state
   logic aw_hold_q, w_hold_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;

   // write path: address and data in either order
   assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
   logic wr_go;
   assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ACT_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr[7:0];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known(aw_addr_q) ? ACT_RESP_OKAY : ACT_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // writable offsets, used by the write response
   function automatic logic wr_known(input logic [7:0] a);
      return a == ACT_OFF_CTRL || a == ACT_OFF_STAT || a == ACT_OFF_RPT || a == ACT_OFF_STPT ||
             a == ACT_OFF_LTH || a == ACT_OFF_UTH;
   endfunction

   // byte-lane merge for 16-bit registers
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   logic wr_ctrl, wr_stat;
   assign wr_ctrl = wr_go && aw_addr_q == ACT_OFF_CTRL;
   assign wr_stat = wr_go && aw_addr_q == ACT_OFF_STAT;

   // plain configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= ACT_CTRL_RST;
         result_left_q <= 1'b0;
         repeat_target_q <= ACT_RPT_RST;
         setpoint_value_q <= 16'h0000;
         lower_threshold_q <= 16'h0000;
         upper_threshold_q <= 16'h0000;
      end else if (wr_go) begin
         if (wr_ctrl) begin
            ctrl_q <= act_ctrl_t'(merge16(ctrl_q, w_data_q, w_strb_q));
            if (w_strb_q[2]) result_left_q <= !w_data_q[ACT_B_FM];
         end
         if (aw_addr_q == ACT_OFF_RPT && w_strb_q[0]) repeat_target_q <= w_data_q[7:0];
         if (aw_addr_q == ACT_OFF_STPT) setpoint_value_q <= merge16(setpoint_value_q, w_data_q, w_strb_q);
         if (aw_addr_q == ACT_OFF_LTH) lower_threshold_q <= merge16(lower_threshold_q, w_data_q, w_strb_q);
         if (aw_addr_q == ACT_OFF_UTH) upper_threshold_q <= merge16(upper_threshold_q, w_data_q, w_strb_q);
      end
   end

   // read path: one read at a time, answered the cycle after it is taken
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= ACT_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= ACT_RESP_OKAY;
         case (s_axi_araddr[7:0])
            ACT_OFF_CTRL: s_axi_rdata <= {13'h0000, accumulator_clear_q, conversion_start_bit,
                                          !result_left_q, 16'(ctrl_q)};
            ACT_OFF_STAT: s_axi_rdata <= {27'h0000000, computation_done_flag_q, lower_compare_flag_q,
                                          upper_compare_flag_q, accumulator_overflow_flag_q, tif_q};
            ACT_OFF_RPT: s_axi_rdata <= {24'h000000, repeat_target_q};
            ACT_OFF_STPT: s_axi_rdata <= {16'h0000, setpoint_value_q};
            ACT_OFF_LTH: s_axi_rdata <= {16'h0000, lower_threshold_q};
            ACT_OFF_UTH: s_axi_rdata <= {16'h0000, upper_threshold_q};
            ACT_OFF_RES: s_axi_rdata <= {16'h0000, fmt(conversion_result_q)};
            ACT_OFF_PREV: s_axi_rdata <= {16'h0000, fmt(previous_result_q)};
            ACT_OFF_ACC: s_axi_rdata <= {16'h0000, sample_accumulator_q};
            ACT_OFF_FLT: s_axi_rdata <= {16'h0000, filter_output_q};
            ACT_OFF_ERR: s_axi_rdata <= {16'h0000, error_value_q};
            ACT_OFF_CNT: s_axi_rdata <= {24'h000000, sample_counter_q};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= ACT_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // justification only affects the software view of results
   function automatic logic [15:0] fmt(input logic [15:0] v);
      return result_left_q ? (v << (16 - RES_W)) : v;
   endfunction

   // sample arithmetic, always right-justified internally
   logic conv_done, first_half, comp_end;
   logic [15:0] new_res, s_term;
   logic [16:0] acc_sum;
   logic [15:0] acc_next, flt_next;
   logic [7:0] cnt_next;
   logic accum_mode, cnt_reached, restart;
   assign conv_done = conv_in.valid;
   assign new_res = 16'(conv_in.data);
   // (RQ19) two conversions per cycle when double sampling
   assign first_half = ctrl_q.dbl_en && !second_pending_q;
   assign comp_end = conv_done && !first_half;
   // (RQ4) right-justified sample term: S1 or S2-S1
   assign s_term = (ctrl_q.dbl_en && !first_half) ? 16'(new_res - conversion_result_q) : new_res;
   assign accum_mode = ctrl_q.mode != 3'(ACT_MD_BASIC) && ctrl_q.mode <= 3'(ACT_MD_LPF);
   // (RQ2) accumulate, (RQ9) low-pass subtracts its own shifted value
   always_comb begin
      if (ctrl_q.mode == 3'(ACT_MD_LPF))
         acc_sum = {1'b0, sample_accumulator_q} + {1'b0, s_term} - {1'b0, sample_accumulator_q >> ctrl_q.shift};
      else
         acc_sum = {1'b0, sample_accumulator_q} + {1'b0, s_term};
      acc_next = acc_sum[15:0];
      // (RQ3) filter output is the shifted accumulator
      flt_next = acc_next >> ctrl_q.shift;
      // (RQ5) count saturates at all ones
      cnt_next = (sample_counter_q == ACT_CNT_MAX) ? sample_counter_q : sample_counter_q + 8'h01;
   end
   // (RQ7) target test on the count including this sample; a restart counts from one
   assign restart = start_fresh_q && (ctrl_q.mode == 3'(ACT_MD_AVG) || ctrl_q.mode == 3'(ACT_MD_BURST));
   assign cnt_reached = (restart ? 8'h01 : cnt_next) >= repeat_target_q;

   // accumulator, counter, overflow and clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sample_accumulator_q <= 16'h0000;
         filter_output_q <= 16'h0000;
         sample_counter_q <= 8'h00;
         accumulator_overflow_flag_q <= 1'b0;
         accumulator_clear_q <= 1'b0;
      end else if (accumulator_clear_q) begin
         // (RQ23) clear completes, bit returns to zero
         sample_accumulator_q <= 16'h0000;
         sample_counter_q <= 8'h00;
         accumulator_overflow_flag_q <= 1'b0;
         accumulator_clear_q <= 1'b0;
      end else if (wr_ctrl && w_strb_q[2] && w_data_q[ACT_B_ACLR]) begin
         accumulator_clear_q <= 1'b1;
      end else if (conv_done && accum_mode && !(ctrl_q.mode == 3'(ACT_MD_BURST) && start_fresh_q)
                   && !(ctrl_q.mode == 3'(ACT_MD_AVG) && start_fresh_q)) begin
         // (RQ2) (RQ20) every sample except an average/burst restart, including first double-sample half
         sample_accumulator_q <= acc_next;
         filter_output_q <= flt_next;
         // (RQ5) count each accumulated sample
         sample_counter_q <= cnt_next;
         // (RQ22) carry out of 16 bits flags overflow, except in low-pass mode
         if (acc_sum[16] && ctrl_q.mode != 3'(ACT_MD_LPF)) accumulator_overflow_flag_q <= 1'b1;
      end else if (conv_done && accum_mode) begin
         // average/burst restart: accumulator starts over from this sample, count set to one
         sample_accumulator_q <= s_term;
         filter_output_q <= s_term >> ctrl_q.shift;
         sample_counter_q <= 8'h01;
      end
   end

   // restart marker for average modes after a target is reached
   always_ff @(posedge aclk) begin
      if (!aresetn || accumulator_clear_q) start_fresh_q <= 1'b0;
      else if (comp_end && (ctrl_q.mode == 3'(ACT_MD_AVG) || ctrl_q.mode == 3'(ACT_MD_BURST)))
         start_fresh_q <= cnt_reached || start_fresh_q && sample_counter_q >= repeat_target_q;
      else if (conv_done) start_fresh_q <= 1'b0;
   end

   // (RQ17) latch results; (RQ21) first half into previous on second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         conversion_result_q <= 16'h0000;
         previous_result_q <= 16'h0000;
         second_pending_q <= 1'b0;
         computation_done_flag_q <= 1'b0;
      end else begin
         if (conv_done) begin
            conversion_result_q <= new_res;
            // (RQ20) done flag on every conversion
            computation_done_flag_q <= 1'b1;
            if (ctrl_q.dbl_en) second_pending_q <= first_half;
            if (first_half) previous_result_q <= previous_result_q;
            else previous_result_q <= ctrl_q.pre_src_sel ? filter_output_q : conversion_result_q;
         end else if (wr_stat && w_strb_q[0] && w_data_q[ACT_B_MATH]) begin
            computation_done_flag_q <= 1'b0;
         end
         if (!ctrl_q.dbl_en) second_pending_q <= 1'b0;
      end
   end

   // (RQ10) (RQ11) error selection; previous is what it becomes this cycle
   logic [15:0] prev_eff, flt_eff, err_d;
   assign prev_eff = ctrl_q.pre_src_sel ? filter_output_q : conversion_result_q;
   assign flt_eff = accum_mode ? (restart ? s_term >> ctrl_q.shift : flt_next) : filter_output_q;
   always_comb begin
      case (ctrl_q.calc)
         3'b000: err_d = new_res - prev_eff;
         3'b001: err_d = s_term - setpoint_value_q;
         3'b010: err_d = s_term - flt_eff;
         3'b100: err_d = prev_eff - flt_eff;
         3'b101: err_d = flt_eff - setpoint_value_q;
         3'b110: err_d = new_res;
         3'b111: err_d = flt_eff;
         default: err_d = 16'h0000; // reserved code
      endcase
   end

   // (RQ12) (RQ15) signed compares
   logic ut_d, lt_d, cond_d, test_now;
   assign ut_d = $signed(err_d) > $signed(upper_threshold_q);
   assign lt_d = $signed(err_d) < $signed(lower_threshold_q);
   // (RQ13) eight threshold conditions
   always_comb begin
      case (ctrl_q.tmode)
         3'd0: cond_d = 1'b0;
         3'd1: cond_d = lt_d;
         3'd2: cond_d = !lt_d;
         3'd3: cond_d = !lt_d && !ut_d;
         3'd4: cond_d = lt_d || ut_d;
         3'd5: cond_d = !ut_d;
         3'd6: cond_d = ut_d;
         default: cond_d = 1'b1;
      endcase
   end
   // (RQ1) (RQ6) (RQ7) (RQ9) when a test is run
   assign test_now = comp_end && (ctrl_q.mode <= 3'(ACT_MD_ACCUM) || cnt_reached);

   // (RQ14) (RQ16) sticky flag, set wins over software clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tif_q <= 1'b0;
         error_value_q <= 16'h0000;
         upper_compare_flag_q <= 1'b0;
         lower_compare_flag_q <= 1'b0;
      end else begin
         if (test_now) begin
            error_value_q <= err_d;
            upper_compare_flag_q <= ut_d;
            lower_compare_flag_q <= lt_d;
         end
         if ((test_now && cond_d) || accumulator_overflow_flag_q) tif_q <= 1'b1;
         else if (wr_stat && w_strb_q[0] && w_data_q[ACT_B_TIF]) tif_q <= 1'b0;
      end
   end
   assign threshold_irq_flag = tif_q;

   // start bit: software sets, hardware retriggers or clears
   logic retrig;
   // (RQ18) continuous until stop-on-interrupt; (RQ8) burst until target
   assign retrig = (ctrl_q.cont_en && !(ctrl_q.stop_irq && (tif_q || (test_now && cond_d))))
                   || (ctrl_q.mode == 3'(ACT_MD_BURST) && comp_end && !cnt_reached)
                   || (ctrl_q.mode == 3'(ACT_MD_BURST) && first_half);
   always_ff @(posedge aclk) begin
      if (!aresetn) conversion_start_bit <= 1'b0;
      else if (conv_done) conversion_start_bit <= retrig;
      else if (wr_ctrl && w_strb_q[2]) conversion_start_bit <= w_data_q[ACT_B_GO];
   end

   // (RQ23) clear bit self-clears one cycle after it is set
   clear_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
      accumulator_clear_q |=> !accumulator_clear_q && sample_counter_q == 8'h00) // (RQ23)
      else $error("clear did not finish");
   // (RQ16) overflow raises threshold flag
   ovf_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      accumulator_overflow_flag_q |=> tif_q) // (RQ16)
      else $error("overflow did not raise threshold flag");
   basic_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      conv_done && ctrl_q.mode == 3'(ACT_MD_BASIC) && !accumulator_clear_q
      |=> $stable(sample_accumulator_q)) // (RQ1)
      else $error("basic mode changed accumulator");
   flt_shift_a: assert property (@(posedge aclk) disable iff (!aresetn)
      conv_done && ctrl_q.mode == 3'(ACT_MD_ACCUM) && !start_fresh_q && !accumulator_clear_q
      && !wr_ctrl |=> filter_output_q == (sample_accumulator_q >> $past(ctrl_q.shift))) // (RQ3)
      else $error("filter output not shifted accumulator");
   cnt_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
      conv_done && ctrl_q.mode == 3'(ACT_MD_ACCUM) && !accumulator_clear_q && !wr_ctrl
      && sample_counter_q != ACT_CNT_MAX |=> sample_counter_q == $past(sample_counter_q) + 8'h01) // (RQ5)
      else $error("counter did not step");
   first_notest_a: assert property (@(posedge aclk) disable iff (!aresetn)
      conv_done && first_half |=> $stable(error_value_q)) // (RQ20)
      else $error("first half updated error");
   tif_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      test_now && cond_d |=> tif_q) // (RQ14)
      else $error("threshold flag not set");
   never_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
      test_now && ctrl_q.tmode == 3'd0 && !tif_q && !accumulator_overflow_flag_q |=> !tif_q) // (RQ13)
      else $error("never mode set flag");
   upper_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      test_now |=> upper_compare_flag_q == ($signed(error_value_q) > $signed($past(upper_threshold_q)))) // (RQ15)
      else $error("upper flag wrong");
endmodule
